// file: ecfrw_cfg.svh
// constants for the egress cpu forwarding and route rewrite slice
`ifndef ECFRW_CFG_SVH
`define ECFRW_CFG_SVH
// register byte addresses (axi4-lite); QFWD and QUNIT are 8-word tables, TAG 2 words, RLEG 32 words, the rest one word each
`define ECFRW_ADDR_QFWD 12'h000
`define ECFRW_ADDR_QUNIT 12'h040
`define ECFRW_ADDR_TAG 12'h080
`define ECFRW_ADDR_MACLO 12'h0c0
`define ECFRW_ADDR_MACHI 12'h0c4
`define ECFRW_ADDR_RLEG 12'h100
`define ECFRW_ADDR_STATUS 12'h200
// router mac type select codes
`define ECFRW_MACSEL_MAPPED_VLAN_INDEX 2'h0
`define ECFRW_MACSEL_VID 2'h1
// destination modes
`define ECFRW_DMODE_L3UC 2'h2
`define ECFRW_DMODE_L3MC 2'h3
// axi responses
`define ECFRW_RESP_OKAY 2'h0
`define ECFRW_RESP_SLVERR 2'h2
`endif

// file: ecfrw_pkg.sv
// types for the egress cpu forwarding and route rewrite slice
package ecfrw_pkg;
    typedef struct packed {
        logic [7:0] header_cpu_queue_mask;
        logic [1:0] header_destination_mode;
        logic header_route_forward_flag;
        logic [4:0] egress_router_leg_index;
        logic [7:0] mapped_vlan_index;
        logic [11:0] frame_vid;
        logic [47:0] analyzer_smac;
        logic [11:0] analyzer_vid;
        logic [2:0] frame_pcp;
        logic stack_port;
        logic [1:0] port_keep_header_selector;
        logic port_stack_header_enable;
    } ecfrw_hdr_t;
    typedef struct packed {
        logic keep_header;
        logic unmodified;
        logic [1:0] tag_count;
        logic [31:0] tag0;
        logic [31:0] tag1;
        logic stack_tag_force;
        logic [15:0] stack_tag;
        logic [4:0] stack_header_dest_port;
        logic [4:0] stack_header_dest_unit;
        logic global_cpu_forwarding_active;
        logic routed;
        logic [47:0] new_smac;
        logic [11:0] new_vid;
        logic stack_was_tagged;
    } ecfrw_act_t;
    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic arready;
        logic awready;
        logic wready;
    } ecfrw_bus_t;
endpackage

// file: ecfrw_cfg_mem.sv
// per-entry configuration word store with two registered read ports (lookup and bus)
`timescale 1ns/1ps
module ecfrw_cfg_mem #(
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // write port
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input wire logic [31:0] wr_data,
    input wire logic [3:0] wr_strb,
    // lookup port for the datapath
    input wire logic [$clog2(DEPTH)-1:0] lk_idx,
    output logic [31:0] lk_data,
    // bus read port
    input wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic [31:0] rd_data
);
    initial
    begin
        if (DEPTH < 2) $error("ecfrw_cfg_mem: DEPTH must be at least 2");
    end
    logic [31:0] mem_q [DEPTH];
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < DEPTH; i++) mem_q[i] <= 32'h0000_0000;
            lk_data <= 32'h0000_0000;
            rd_data <= 32'h0000_0000;
        end
        else
        begin
            if (wr_en)
            begin
                for (int b = 0; b < 4; b++)
                    if (wr_strb[b]) mem_q[wr_idx][b*8 +: 8] <= wr_data[b*8 +: 8];
            end
            lk_data <= mem_q[lk_idx];
            rd_data <= mem_q[rd_idx];
        end
    end
endmodule // ecfrw_cfg_mem

// file: ecfrw_top.sv
// egress cpu forwarding and router-leg rewrite decision stage with axi4-lite registers
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "ecfrw_cfg.svh"
module ecfrw_top #(
    parameter int NUM_QUEUES = 8,
    parameter int NUM_LEGS = 32
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // axi4-lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // header in from queue system
    input wire logic hdr_valid,
    input wire ecfrw_pkg::ecfrw_hdr_t hdr_in,
    // rewrite action out to the frame editor
    output logic act_valid,
    output ecfrw_pkg::ecfrw_act_t act_out
);
    initial
    begin
        if (NUM_QUEUES != 8) $error("ecfrw_top: NUM_QUEUES must be 8 (mask width)");
        if (NUM_LEGS != 32) $error("ecfrw_top: NUM_LEGS must be 32 (leg index width)");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        ecfrw_pkg::ecfrw_bus_t bus;
        logic [31:0] tag_cfg0;
        logic [31:0] tag_cfg1;
        logic [31:0] mac_lo;
        logic [31:0] mac_hi;
        logic s1_valid;
        ecfrw_pkg::ecfrw_hdr_t s1_hdr;
        logic s1_global_cpu_forwarding;
        logic [2:0] s1_queue;
        logic act_valid;
        ecfrw_pkg::ecfrw_act_t act;
        logic [15:0] frame_count;
    } ecfrw_state_t;
    ecfrw_state_t st_q;
    ecfrw_state_t st_d;

    ////////////////////////////////////////////////////////////////////////////////
    // write/read decode into the three tables
    logic wr_fire;
    logic [11:0] wa;
    logic wr_qfwd;
    logic wr_qunit;
    logic wr_rleg;
    logic [31:0] qfwd_lk;
    logic [31:0] qunit_lk;
    logic [31:0] rleg_lk;
    logic [31:0] qfwd_rd;
    logic [31:0] qunit_rd;
    logic [31:0] rleg_rd;
    logic [2:0] s0_queue;
    logic s0_any;
    logic [11:0] ra_q;
    assign wr_fire = st_q.bus.aw_got && st_q.bus.w_got && !st_q.bus.bvalid;
    assign wa = st_q.bus.awaddr;
    assign wr_qfwd = wr_fire && wa[11:5] == 7'(`ECFRW_ADDR_QFWD >> 5);
    assign wr_qunit = wr_fire && wa[11:5] == 7'(`ECFRW_ADDR_QUNIT >> 5);
    assign wr_rleg = wr_fire && wa[11:7] == 5'(`ECFRW_ADDR_RLEG >> 7);

    // highest set mask bit wins empty mask means no forwarding
    always_comb
    begin
        s0_queue = 3'h0;
        for (int i = 0; i < NUM_QUEUES; i++)
            if (hdr_in.header_cpu_queue_mask[i]) s0_queue = 3'(i);
        s0_any = |hdr_in.header_cpu_queue_mask;
    end

    ecfrw_cfg_mem #(.DEPTH(NUM_QUEUES)) u_qfwd (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .wr_en(wr_qfwd), .wr_idx(wa[4:2]),
        .wr_data(st_q.bus.wdata), .wr_strb(st_q.bus.wstrb), .lk_idx(s0_queue),
        .lk_data(qfwd_lk), .rd_idx(s_axi_araddr[4:2]), .rd_data(qfwd_rd)
    );
    ecfrw_cfg_mem #(.DEPTH(NUM_QUEUES)) u_qunit (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .wr_en(wr_qunit), .wr_idx(wa[4:2]),
        .wr_data(st_q.bus.wdata), .wr_strb(st_q.bus.wstrb), .lk_idx(s0_queue),
        .lk_data(qunit_lk), .rd_idx(s_axi_araddr[4:2]), .rd_data(qunit_rd)
    );
    ecfrw_cfg_mem #(.DEPTH(NUM_LEGS)) u_rleg (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .wr_en(wr_rleg), .wr_idx(wa[6:2]),
        .wr_data(st_q.bus.wdata), .wr_strb(st_q.bus.wstrb),
        .lk_idx(hdr_in.egress_router_leg_index),
        .lk_data(rleg_lk), .rd_idx(s_axi_araddr[6:2]), .rd_data(rleg_rd)
    );

    // tables see the bus address directly, so their word is ready one cycle
    // after the accept; the held copy only steers the read mux
    logic rd_pend_q;
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ra_q <= 12'h000;
            rd_pend_q <= 1'b0;
        end
        else
        begin
            rd_pend_q <= s_axi_arvalid && st_q.bus.arready;
            if (s_axi_arvalid && st_q.bus.arready) ra_q <= s_axi_araddr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // datapath helper values
    logic [23:0] mac_low_mapped_vlan_index;
    logic [23:0] mac_low_vid;
    logic [31:0] tag_sel;
    logic [31:0] mk_tag0;
    logic [31:0] mk_tag1;
    logic keep_ok;
    always_comb
    begin
        mac_low_mapped_vlan_index = st_q.mac_lo[23:0] + {16'h0000, st_q.s1_hdr.mapped_vlan_index};
        mac_low_vid = st_q.mac_lo[23:0] + {12'h000, st_q.s1_hdr.frame_vid};
        tag_sel = st_q.tag_cfg0;
        // tag word: [31:16] tpid, [15:13] pcp, [12] dei, [11:0] vid
        mk_tag0 = {(st_q.tag_cfg0[17] ? 16'h88a8 : 16'h8100),
            (st_q.tag_cfg0[16] ? st_q.s1_hdr.frame_pcp : st_q.tag_cfg0[15:13]),
            st_q.tag_cfg0[12:0]};
        mk_tag1 = {(st_q.tag_cfg1[17] ? 16'h88a8 : 16'h8100),
            (st_q.tag_cfg1[16] ? st_q.s1_hdr.frame_pcp : st_q.tag_cfg1[15:13]),
            st_q.tag_cfg1[12:0]};
        // keep-header is void on ports with their own keep selector or stack header
        keep_ok = qfwd_lk[0] && st_q.s1_hdr.port_keep_header_selector == 2'h0
            && !st_q.s1_hdr.port_stack_header_enable;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        st_d = st_q;
        // axi write channels taken in either order
        st_d.bus.awready = !st_q.bus.aw_got && !st_q.bus.bvalid;
        st_d.bus.wready = !st_q.bus.w_got && !st_q.bus.bvalid;
        if (s_axi_awvalid && st_q.bus.awready)
        begin
            st_d.bus.aw_got = 1'b1;
            st_d.bus.awaddr = s_axi_awaddr;
            st_d.bus.awready = 1'b0;
        end
        if (s_axi_wvalid && st_q.bus.wready)
        begin
            st_d.bus.w_got = 1'b1;
            st_d.bus.wdata = s_axi_wdata;
            st_d.bus.wstrb = s_axi_wstrb;
            st_d.bus.wready = 1'b0;
        end
        if (wr_fire)
        begin
            st_d.bus.bvalid = 1'b1;
            st_d.bus.bresp = `ECFRW_RESP_OKAY;
            st_d.bus.aw_got = 1'b0;
            st_d.bus.w_got = 1'b0;
            case (wa)
                `ECFRW_ADDR_TAG: st_d.tag_cfg0 = st_q.bus.wdata;
                `ECFRW_ADDR_TAG + 12'h004: st_d.tag_cfg1 = st_q.bus.wdata;
                `ECFRW_ADDR_MACLO: st_d.mac_lo = st_q.bus.wdata;
                `ECFRW_ADDR_MACHI: st_d.mac_hi = st_q.bus.wdata;
                default:
                begin
                    if (!(wr_qfwd || wr_qunit || wr_rleg))
                        st_d.bus.bresp = `ECFRW_RESP_SLVERR;
                end
            endcase
        end
        if (st_q.bus.bvalid && s_axi_bready) st_d.bus.bvalid = 1'b0;
        // read: accept, wait one cycle for table data, then answer
        st_d.bus.arready = !st_q.bus.rvalid && !rd_pend_q
            && !(s_axi_arvalid && st_q.bus.arready);
        if (rd_pend_q)
        begin
            st_d.bus.rvalid = 1'b1;
            st_d.bus.rresp = `ECFRW_RESP_OKAY;
            if (ra_q[11:5] == 7'(`ECFRW_ADDR_QFWD >> 5)) st_d.bus.rdata = qfwd_rd;
            else if (ra_q[11:5] == 7'(`ECFRW_ADDR_QUNIT >> 5)) st_d.bus.rdata = qunit_rd;
            else if (ra_q[11:7] == 5'(`ECFRW_ADDR_RLEG >> 7)) st_d.bus.rdata = rleg_rd;
            else
            begin
                case (ra_q)
                    `ECFRW_ADDR_TAG: st_d.bus.rdata = st_q.tag_cfg0;
                    `ECFRW_ADDR_TAG + 12'h004: st_d.bus.rdata = st_q.tag_cfg1;
                    `ECFRW_ADDR_MACLO: st_d.bus.rdata = st_q.mac_lo;
                    `ECFRW_ADDR_MACHI: st_d.bus.rdata = st_q.mac_hi;
                    `ECFRW_ADDR_STATUS: st_d.bus.rdata = {16'h0000, st_q.frame_count};
                    default:
                    begin
                        st_d.bus.rdata = 32'h0000_0000;
                        st_d.bus.rresp = `ECFRW_RESP_SLVERR;
                    end
                endcase
            end
        end
        if (st_q.bus.rvalid && s_axi_rready) st_d.bus.rvalid = 1'b0;

        // stage 1: tables are looked up on the same edge as the header register
        st_d.s1_valid = hdr_valid;
        if (hdr_valid)
        begin
            st_d.s1_hdr = hdr_in;
            st_d.s1_global_cpu_forwarding = s0_any;
            st_d.s1_queue = s0_queue;
        end

        // stage 2: build the action
        st_d.act_valid = st_q.s1_valid;
        if (st_q.s1_valid)
        begin
            st_d.frame_count = st_q.frame_count + 16'h0001;
            st_d.act = '0;
            st_d.act.global_cpu_forwarding_active = st_q.s1_global_cpu_forwarding;
            if (st_q.s1_global_cpu_forwarding)
            begin
                if (st_q.s1_hdr.stack_port)
                begin
                    st_d.act.stack_tag_force = qfwd_lk[3:2] != 2'h0;
                    st_d.act.stack_tag = tag_sel[15:0];
                    // mode 0 uses the qunit entry's low three bits as is, else offsets them by 24 into upper queues
                    st_d.act.stack_header_dest_port = qfwd_lk[4]
                        ? {2'h3, qunit_lk[2:0]} : {2'h0, qunit_lk[2:0]};
                    st_d.act.stack_header_dest_unit = qfwd_lk[12:8];
                end
                else if (keep_ok)
                begin
                    st_d.act.keep_header = 1'b1;
                end
                else
                begin
                    st_d.act.unmodified = qfwd_lk[1];
                    st_d.act.tag_count = qfwd_lk[3:2] == 2'h3 ? 2'h2 : qfwd_lk[3:2];
                    st_d.act.tag0 = mk_tag0;
                    st_d.act.tag1 = mk_tag1;
                end
            end
            else if (st_q.s1_hdr.header_destination_mode == `ECFRW_DMODE_L3UC
                || st_q.s1_hdr.header_destination_mode == `ECFRW_DMODE_L3MC)
            begin
                st_d.act.routed = 1'b1;
                if (st_q.s1_hdr.header_route_forward_flag)
                begin
                    st_d.act.new_smac = st_q.s1_hdr.analyzer_smac;
                    st_d.act.new_vid = st_q.s1_hdr.analyzer_vid;
                end
                else
                begin
                    case (st_q.mac_hi[25:24])
                        `ECFRW_MACSEL_MAPPED_VLAN_INDEX:
                            st_d.act.new_smac = {st_q.mac_hi[23:0], mac_low_mapped_vlan_index};
                        `ECFRW_MACSEL_VID:
                            st_d.act.new_smac = {st_q.mac_hi[23:0], mac_low_vid};
                        default:
                            st_d.act.new_smac = {st_q.mac_hi[23:0], st_q.mac_lo[23:0]};
                    endcase
                    st_d.act.new_vid = rleg_lk[11:0];
                end
                st_d.act.stack_was_tagged = st_q.s1_hdr.stack_port && rleg_lk[12];
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst) st_q <= '0;
        else st_q <= st_d;
    end

    assign s_axi_awready = st_q.bus.awready;
    assign s_axi_wready = st_q.bus.wready;
    assign s_axi_bvalid = st_q.bus.bvalid;
    assign s_axi_bresp = st_q.bus.bresp;
    assign s_axi_arready = st_q.bus.arready;
    assign s_axi_rvalid = st_q.bus.rvalid;
    assign s_axi_rdata = st_q.bus.rdata;
    assign s_axi_rresp = st_q.bus.rresp;
    assign act_valid = st_q.act_valid;
    assign act_out = st_q.act;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence s_hdr_zero;
        hdr_valid && hdr_in.header_cpu_queue_mask == 8'h00;
    endsequence
    sequence s_routed_hdr;
        hdr_valid && hdr_in.header_cpu_queue_mask == 8'h00
            && hdr_in.header_destination_mode[1];
    endsequence
    AST_NO_GLOBAL_CPU_FORWARDING_ZERO_MASK: assert property (
        s_hdr_zero |=> ##1 (act_valid && !act_out.global_cpu_forwarding_active))
        else $error("zero cpu mask produced forwarding");
    AST_LATENCY: assert property (hdr_valid |-> ##2 act_valid)
        else $error("action not two cycles after header");
    AST_KEEP_EXCLUSIVE: assert property (
        act_valid && act_out.keep_header |-> act_out.tag_count == 2'h0 && !act_out.unmodified)
        else $error("keep header with other rewrites");
    AST_ROUTED_MODE: assert property (s_routed_hdr |=> ##1 act_out.routed)
        else $error("routing mode not rewritten");
    AST_NOT_ROUTED: assert property (
        hdr_valid && !hdr_in.header_destination_mode[1] |-> ##2 !act_out.routed)
        else $error("non-routed frame rewritten");
    AST_RTFWD: assert property (
        (s_routed_hdr and hdr_in.header_route_forward_flag)
            |=> ##1 act_out.new_smac == $past(hdr_in.analyzer_smac, 2))
        else $error("analyzer mac not used");
    AST_KEEP_STACK: assert property (
        act_valid && act_out.keep_header |-> !$past(st_q.s1_hdr.port_stack_header_enable))
        else $error("keep header on stack header port");
    // type select and mac parts count in the cycle in which the action is built
    AST_COMMON_MAC: assert property (
        (s_routed_hdr and !hdr_in.header_route_forward_flag) ##1 st_q.mac_hi[25:24] == 2'h3
            |=> act_out.new_smac == {$past(st_q.mac_hi[23:0]), $past(st_q.mac_lo[23:0])})
        else $error("common router mac wrong");
    AST_TAGS_FRONT: assert property (
        act_valid && act_out.tag_count != 2'h0 |-> !act_out.stack_tag_force)
        else $error("tags on stack port");
endmodule // ecfrw_top

// file: ecfrw_hdr_src.sv
// header source model standing in for the output queue system
`timescale 1ns/1ps
module ecfrw_hdr_src #(
    parameter logic [7:0] QUEUE_FWD_ENABLE = 8'hff
) (
    // clock
    input wire logic clk_sys,
    // header out
    output logic hdr_valid,
    output ecfrw_pkg::ecfrw_hdr_t hdr_in
);
    initial
    begin
        hdr_valid = 1'b0;
        hdr_in = '0;
    end
    // one header per call; the caller lets the answer arrive before the next call
    task automatic send(input ecfrw_pkg::ecfrw_hdr_t h);
        begin
            // a queue not enabled for forwarding never reaches the rewriter
            h.header_cpu_queue_mask = h.header_cpu_queue_mask & QUEUE_FWD_ENABLE;
            hdr_in <= h;
            hdr_valid <= 1'b1;
            @(posedge clk_sys);
            hdr_valid <= 1'b0;
            // stale header must not look like the last one between frames
            hdr_in <= ~h;
        end
    endtask
endmodule // ecfrw_hdr_src

// file: ecfrw_top_tb_top.sv
// self-checking bench for the cpu forwarding and route rewrite stage
`timescale 1ns/1ps
`include "ecfrw_cfg.svh"
module ecfrw_top_tb_top;
    typedef struct packed {
        ecfrw_pkg::ecfrw_hdr_t h;
        logic [5:0] f;
        logic [47:0] smac;
        logic [11:0] vid;
    } ecfrw_row_t;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, hdr_valid, act_valid;
    logic [1:0] bresp, rresp;
    ecfrw_pkg::ecfrw_hdr_t hdr_in;
    ecfrw_pkg::ecfrw_act_t act;
    ecfrw_row_t rows [11];
    int err_count = 0;
    int comparisons = 0;
    int t;
    logic [23:0] lo;
    ecfrw_hdr_src i_src (.clk_sys(clk_sys), .hdr_valid(hdr_valid), .hdr_in(hdr_in));
    ecfrw_top #(.NUM_QUEUES(8), .NUM_LEGS(32)) i_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .hdr_valid(hdr_valid), .hdr_in(hdr_in), .act_valid(act_valid), .act_out(act));
    initial
    begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        begin
            $display("checks %0d mismatches %0d", comparisons, err_count);
            if (err_count == 0 && comparisons > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
        begin
            comparisons++;
            if (seen !== exp)
            begin
                err_count++;
                $display("wrong value %s expected %h seen %h", n, exp, seen);
            end
        end
    endtask
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        int n;
        begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            for (n = 0; n < 50; n++)
            begin
                @(posedge clk_sys);
                if (awvalid && awready) awvalid <= 1'b0;
                if (wvalid && wready) wvalid <= 1'b0;
                if (bvalid) break;
            end
            if (n == 50)
            begin
                err_count++;
                report_and_stop();
            end
            chk("bresp", bresp, `ECFRW_RESP_OKAY);
            // one idle edge so the next call never re-raises bready in this step
            bready <= 1'b0;
            @(posedge clk_sys);
        end
    endtask
    task automatic axr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            for (n = 0; n < 50; n++)
            begin
                @(posedge clk_sys);
                if (arvalid && arready) arvalid <= 1'b0;
                if (rvalid) break;
            end
            if (n == 50)
            begin
                err_count++;
                report_and_stop();
            end
            chk("rdata", rdata, d);
            chk("rresp", rresp, r);
            rready <= 1'b0;
            @(posedge clk_sys);
        end
    endtask
    // sends one header and waits for its action word
    task automatic frm(input ecfrw_pkg::ecfrw_hdr_t h);
        int n;
        begin
            i_src.send(h);
            for (n = 0; n < 8; n++)
            begin
                @(posedge clk_sys);
                if (act_valid === 1'b1) break;
            end
            if (n == 8) begin err_count++; report_and_stop(); end
        end
    endtask
    // p: route-forward flag, stack port, port keep selector, port stack header enable
    function automatic ecfrw_pkg::ecfrw_hdr_t hd(input logic [7:0] m, input logic [1:0] dm,
        input logic [4:0] lg, input logic [3:0] p);
        ecfrw_pkg::ecfrw_hdr_t h;
        begin
            h = '0;
            h.header_cpu_queue_mask = m;
            h.header_destination_mode = dm;
            h.egress_router_leg_index = lg;
            h.header_route_forward_flag = p[3];
            h.stack_port = p[2];
            h.port_keep_header_selector = {1'b0, p[1]};
            h.port_stack_header_enable = p[0];
            h.mapped_vlan_index = 8'h20;
            h.frame_vid = 12'h100;
            h.analyzer_smac = 48'h020000000001;
            h.analyzer_vid = 12'h0ab;
            hd = h;
        end
    endfunction
    ////////////////////////////////////////////////////////////////////////////////////
    // f: global_cpu_forwarding, keep header, unmodified, tag count, routed
    initial
    begin
        rows[0] = '{hd(8'h00, 2'h0, 5'h00, 4'h0), 6'b000000, 48'h0, 12'h0};
        rows[1] = '{hd(8'ha8, 2'h0, 5'h00, 4'h0), 6'b110000, 48'h0, 12'h0};
        rows[2] = '{hd(8'h80, 2'h0, 5'h00, 4'h2), 6'b100100, 48'h0, 12'h0};
        rows[3] = '{hd(8'h80, 2'h0, 5'h00, 4'h1), 6'b100100, 48'h0, 12'h0};
        rows[4] = '{hd(8'h28, 2'h0, 5'h00, 4'h0), 6'b101010, 48'h0, 12'h0};
        rows[5] = '{hd(8'h08, 2'h0, 5'h00, 4'h0), 6'b100100, 48'h0, 12'h0};
        rows[6] = '{hd(8'h00, 2'h2, 5'h03, 4'h0), 6'b000001, 48'h0a0b0c000010, 12'h064};
        rows[7] = '{hd(8'h00, 2'h3, 5'h1f, 4'h0), 6'b000001, 48'h0a0b0c000010, 12'h7ff};
        rows[8] = '{hd(8'h00, 2'h1, 5'h03, 4'h0), 6'b000000, 48'h0, 12'h0};
        rows[9] = '{hd(8'h00, 2'h2, 5'h03, 4'h8), 6'b000001, 48'h020000000001, 12'h0ab};
        rows[10] = '{hd(8'h01, 2'h2, 5'h03, 4'h0), 6'b100000, 48'h0, 12'h0};
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        chk("act_valid", act_valid, 1'b0);
        axw(12'h01c, 32'h0000_0009);
        axw(12'h014, 32'h0000_0b16);
        axw(12'h00c, 32'h0000_030c);
        axw(12'h054, 32'h0000_0006);
        axw(12'h04c, 32'h0000_0002);
        axw(12'h080, 32'h0002_a00a);
        axw(12'h084, 32'h0000_2123);
        // router mac low part sits near the 24-bit top so an added index or vid wraps
        axw(`ECFRW_ADDR_MACLO, 32'h00ff_fff0);
        axw(`ECFRW_ADDR_MACHI, 32'h000a_0b0c);
        axw(12'h10c, 32'h0000_1064);
        axw(12'h17c, 32'h0000_07ff);
        axr(`ECFRW_ADDR_MACHI, 32'h000a_0b0c, `ECFRW_RESP_OKAY);
        axr(12'h3fc, 32'h0, `ECFRW_RESP_SLVERR);
        axr(12'h014, 32'h0000_0b16, `ECFRW_RESP_OKAY);
        axr(12'h10c, 32'h0000_1064, `ECFRW_RESP_OKAY);
        for (int i = 0; i < 11; i++)
        begin
            frm(rows[i].h);
            chk("flags", {act.global_cpu_forwarding_active, act.keep_header, act.unmodified, act.tag_count,
                act.routed}, rows[i].f);
            if (rows[i].f[0])
            begin
                chk("smac", act.new_smac, rows[i].smac);
                chk("vid", act.new_vid, rows[i].vid);
            end
        end
        frm(hd(8'h08, 2'h0, 5'h00, 4'h0));
        chk("tag0", act.tag0, {16'h88a8, 16'ha00a});
        chk("tag1", act.tag1, {16'h8100, 16'h2123});
        for (t = 1; t < 4; t++)
        begin
            axw(`ECFRW_ADDR_MACHI, {6'h0, t[1:0], 24'h0a0b0c});
            lo = (t == 1) ? 24'h0000f0 : 24'hfffff0;
            frm(hd(8'h00, 2'h2, 5'h03, 4'h0));
            chk("smac_sel", act.new_smac, {24'h0a0b0c, lo});
        end
        frm(hd(8'h20, 2'h0, 5'h00, 4'h4));
        chk("dport", act.stack_header_dest_port, 5'h1e);
        chk("dunit", act.stack_header_dest_unit, 5'h0b);
        chk("tforce", act.stack_tag_force, 1'b1);
        chk("stag", act.stack_tag, 16'ha00a);
        frm(hd(8'h08, 2'h0, 5'h00, 4'h4));
        chk("dport0", act.stack_header_dest_port, 5'h02);
        chk("dunit0", act.stack_header_dest_unit, 5'h03);
        frm(hd(8'h00, 2'h2, 5'h03, 4'h4));
        chk("wastag", act.stack_was_tagged, 1'b1);
        // mid-run reset clears the action output and the leg table
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        chk("act_valid_rst", act_valid, 1'b0);
        axr(12'h10c, 32'h0000_0000, `ECFRW_RESP_OKAY);
        report_and_stop();
    end
endmodule // ecfrw_top_tb_top
